// >>> verilog/selftest_responder_defines.vh
`ifndef SELFTEST_RESPONDER_DEFINES_VH
`define SELFTEST_RESPONDER_DEFINES_VH

// ------------------------------------------------------------
// command and message identifiers
// ------------------------------------------------------------
`define CMD_TEST_DATA 8'h11
`define CMD_SELF_TEST 8'h07
`define MSG_TEST_DATA 8'h09
`define MSG_SELF_TEST 8'h07

// ------------------------------------------------------------
// message layout
// ------------------------------------------------------------
`define DEGREES 7'd30
`define TD_BYTES 7'd120
`define TD_MSG_LEN 7'd121
`define ST_MSG_LEN 7'd3
`define INTENSITY_MAX 8'h7f
`define RANGE1_FIRST 7'h3c
`define WIDTH1_FIRST 7'h5a

// ------------------------------------------------------------
// fault word bit positions
// ------------------------------------------------------------
`define FLT_APP_IMAGE 0
`define FLT_PARAM_IMAGE 1

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FAULT 12'h008
`define REG_IRQ_STAT 12'h00c
`define REG_IRQ_MASK 12'h010
`define REG_TD_BASE 12'h100
`define REG_TD_LAST 12'h2dc

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_AUTO 1
`define CTRL_RESET 2'h3
`define IRQ_TD_DONE 0
`define IRQ_ST_DONE 1
`define IRQ_NEW_FAULT 2
`define IRQ_BAD_CMD 3
`define IRQ_RESET 4'h0

`endif

// >>> verilog/selftest_responder.v
// Notes on behaviour
// - command 17 makes the device send a test data message
// - test data message opens with identifier byte 9
// - then 30 range bytes of beam two, quarter-foot steps
// - then 30 pulse-width bytes of beam two, held to 0..127
// - then beam one range and pulse-width arrays, same coding
// - command 7 runs self-test, answer opens with identifier byte 7
// - a newly detected fault sends the self-test message unprompted
// - identifier followed by 16-bit fault word, set bit means failed
// - bit 0 application image, bit 1 parameter image; boot loader only
// - bits 2..7: -5V, memory test, motor, +5V, photodiode temp, window temp
// - bits 8..15: calibration, threshold, HV gain, humidity, resyncs, 3V, 24V, port
// - commands and replies share one 57.6 kbps serial link
`timescale 1ns/1ps
`include "selftest_responder_defines.vh"

module selftest_responder (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  output reg tx_valid,
  output reg [7:0] tx_byte,
  input wire tx_ready,
  input wire [15:0] fault_in,
  output reg app_run,
  output reg irq
);

  // ------------------------------------------------------------
  // state encoding
  // ------------------------------------------------------------
  // one-hot sequencer states
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_TD = 3'b010;
  localparam [2:0] S_ST = 3'b100;

  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  // sequencer, synchroniser, request and register flops
  reg [2:0] state_ff;
  reg [6:0] cnt_ff;
  reg [15:0] fault_meta_ff;
  reg [15:0] fault_sync_ff;
  reg [15:0] fault_prev_ff;
  reg [15:0] fault_snap_ff;
  reg td_pend_ff;
  reg st_pend_ff;
  reg [1:0] ctrl_ff;
  reg [3:0] irq_stat_ff;
  reg [3:0] irq_mask_ff;
  reg [7:0] td_mem [0:119];
  reg [7:0] nxt_byte;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  // ------------------------------------------------------------
  // bus, command and message decode
  // ------------------------------------------------------------
  // access phase before and at the answer
  wire acc_first = psel & penable & ~pready;
  wire acc_done = psel & penable & pready;
  wire wr_done = acc_done & pwrite;
  wire in_td = (paddr >= `REG_TD_BASE) && (paddr <= `REG_TD_LAST) && (paddr[1:0] == 2'b00);
  wire [11:0] td_off = paddr - `REG_TD_BASE;
  wire [6:0] td_idx = td_off[8:2];
  wire slot_free = ~tx_valid | tx_ready;
  wire busy = ~state_ff[0];
  // command bytes from the link, ignored while disabled
  wire cmd_td = rx_valid & ctrl_ff[`CTRL_ENABLE] & (rx_byte == `CMD_TEST_DATA);
  wire cmd_st = rx_valid & ctrl_ff[`CTRL_ENABLE] & (rx_byte == `CMD_SELF_TEST);
  wire cmd_bad = rx_valid & ctrl_ff[`CTRL_ENABLE] & ~cmd_td & ~cmd_st;
  wire [15:0] fault_rise = fault_sync_ff & ~fault_prev_ff;
  wire new_fault = |fault_rise;
  // message ends once its last byte is taken
  wire td_end = state_ff[1] & slot_free & (cnt_ff == `TD_MSG_LEN);
  wire st_end = state_ff[2] & slot_free & (cnt_ff == `ST_MSG_LEN);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // pulse-width slots are the second and fourth groups of 30
  function is_intensity;
    input [6:0] idx;
    begin
      is_intensity = ((idx >= `DEGREES) && (idx < `RANGE1_FIRST)) || (idx >= `WIDTH1_FIRST);
    end
  endfunction

  // clamp a stored pulse width to the legal range
  function [7:0] clamp_int;
    input [7:0] b;
    begin
      clamp_int = b[7] ? `INTENSITY_MAX : b;
    end
  endfunction

  // ------------------------------------------------------------
  // outgoing byte selection
  // ------------------------------------------------------------
  // byte at position cnt of the active message
  always @* begin
    nxt_byte = 8'h00;
    if (state_ff[1]) begin
      if (cnt_ff == 7'd0) begin
        nxt_byte = `MSG_TEST_DATA;
      end else if (is_intensity(cnt_ff - 7'd1)) begin
        nxt_byte = clamp_int(td_mem[cnt_ff - 7'd1]);
      end else begin
        nxt_byte = td_mem[cnt_ff - 7'd1];
      end
    end else if (state_ff[2]) begin
      case (cnt_ff)
        7'd0: nxt_byte = `MSG_SELF_TEST;
        7'd1: nxt_byte = fault_snap_ff[15:8];
        default: nxt_byte = fault_snap_ff[7:0];
      endcase
    end
  end

  // ------------------------------------------------------------
  // fault input synchroniser
  // ------------------------------------------------------------
  // monitor lines come from outside the clock domain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_meta_ff <= 16'h0000;
      fault_sync_ff <= 16'h0000;
      fault_prev_ff <= 16'h0000;
    end else begin
      fault_meta_ff <= fault_in;
      fault_sync_ff <= fault_meta_ff;
      fault_prev_ff <= fault_sync_ff;
    end
  end

  // ------------------------------------------------------------
  // pending requests
  // ------------------------------------------------------------
  // requests wait here while a message is on the link
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      td_pend_ff <= 1'b0;
      st_pend_ff <= 1'b0;
    end else begin
      if (cmd_td) begin
        td_pend_ff <= 1'b1;
      end else if (state_ff[0] & ~st_pend_ff & td_pend_ff) begin
        td_pend_ff <= 1'b0;
      end
      if (cmd_st | (new_fault & ctrl_ff[`CTRL_AUTO])) begin
        st_pend_ff <= 1'b1;
      end else if (state_ff[0] & st_pend_ff) begin
        st_pend_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // message sequencer
  // ------------------------------------------------------------
  // one message at a time, self-test first when both wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      cnt_ff <= 7'd0;
      fault_snap_ff <= 16'h0000;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
          end
          cnt_ff <= 7'd0;
          if (st_pend_ff) begin
            state_ff <= S_ST;
            fault_snap_ff <= fault_sync_ff;
          end else if (td_pend_ff) begin
            state_ff <= S_TD;
          end
        end
        S_TD, S_ST: begin
          if (td_end | st_end) begin
            state_ff <= S_IDLE;
            tx_valid <= 1'b0;
          end else if (slot_free) begin
            tx_valid <= 1'b1;
            tx_byte <= nxt_byte;
            cnt_ff <= cnt_ff + 7'd1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          tx_valid <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // application run gate
  // ------------------------------------------------------------
  // image faults hold the application, boot loader only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_run <= 1'b0;
    end else begin
      app_run <= ~(fault_sync_ff[`FLT_APP_IMAGE] | fault_sync_ff[`FLT_PARAM_IMAGE]);
    end
  end

  // ------------------------------------------------------------
  // test data array
  // ------------------------------------------------------------
  // software loads the per-degree arrays in message order
  always @(posedge pclk) begin
    if (wr_done & in_td) begin
      td_mem[td_idx] <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // control and interrupt registers
  // ------------------------------------------------------------
  // set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
      irq_mask_ff <= `IRQ_RESET;
      irq_stat_ff <= `IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_done && paddr == `REG_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
      if (wr_done && paddr == `REG_IRQ_MASK) begin
        irq_mask_ff <= pwdata[3:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~((wr_done && paddr == `REG_IRQ_STAT) ?
                     pwdata[3:0] : 4'h0)) |
                     {cmd_bad, new_fault, st_end, td_end};
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ------------------------------------------------------------
  // apb read decode
  // ------------------------------------------------------------
  // unmapped addresses answer with an error
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    if (in_td) begin
      nxt_rdata = {24'h000000, td_mem[td_idx]};
    end else begin
      case (paddr)
        `REG_CTRL: nxt_rdata = {30'h00000000, ctrl_ff};
        `REG_STATUS: nxt_rdata = {28'h0000000, app_run, st_pend_ff, td_pend_ff, busy};
        `REG_FAULT: nxt_rdata = {fault_snap_ff, fault_sync_ff};
        `REG_IRQ_STAT: nxt_rdata = {28'h0000000, irq_stat_ff};
        `REG_IRQ_MASK: nxt_rdata = {28'h0000000, irq_mask_ff};
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------
  // one wait state, answer registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & nxt_err;
      // reads load data; refused accesses read as zero
      if (acc_first & (~pwrite | nxt_err)) begin
        prdata <= nxt_rdata;
      end
    end
  end

endmodule

// >>> tb/selftest_responder_monitor.sv
`timescale 1ns/1ps
module selftest_responder_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire tx_valid,
  input wire [7:0] tx_byte,
  input wire tx_ready,
  input wire [15:0] fault_in,
  input wire app_run
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // bus answer
  // ----
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait");
  property p_pulse; pready |-> psel && penable ##1 !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("slverr without pready");
  // ----
  // message stream and application run gate
  // ----
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("tx byte not held");
  property p_first; $rose(tx_valid) |-> tx_byte == 8'h09 || tx_byte == 8'h07; endproperty
  a_first: assert property (p_first) else $error("bad message id");
  property p_gap; $fell(tx_valid) |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle between messages");
  property p_boot; (|fault_in[1:0])[*4] |-> !app_run; endproperty
  a_boot: assert property (p_boot) else $error("app runs on image fault");
  property p_run; (fault_in[1:0] == 2'h0)[*4] |-> app_run; endproperty
  a_run: assert property (p_run) else $error("app stopped without fault");
endmodule

// >>> tb/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
  input wire pclk,
  input wire slow,
  output reg rx_valid,
  output reg [7:0] rx_byte,
  output reg tx_ready
);
  reg [1:0] cnt_ff;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
    cnt_ff = 2'h0;
  end
  // take bytes at once, or one cycle in four when slow
  always @(posedge pclk) begin
    cnt_ff <= cnt_ff + 2'h1;
    tx_ready <= !slow || cnt_ff == 2'h3;
  end
  // one-byte command as a one-cycle pulse
  task send(input [7:0] id);
    begin
      rx_valid <= 1'b1;
      rx_byte <= id;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_byte <= ~id;
      @(posedge pclk);
    end
  endtask
endmodule

// >>> tb/selftest_responder_tb.sv
`timescale 1ns/1ps
`include "selftest_responder_defines.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module selftest_responder_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd, lfsr = 32'h1121;
  reg [15:0] fault_in = 16'h0000;
  reg [7:0] expq[$];
  reg [7:0] b;
  wire [31:0] prdata;
  wire pready, pslverr, rx_valid, tx_valid, tx_ready, app_run, irq;
  wire [7:0] rx_byte, tx_byte;
  integer num_errors = 0, cmp_count = 0, i, k;
  selftest_responder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .fault_in(fault_in), .app_run(app_run), .irq(irq));
  link_host_model i_host (.pclk(pclk), .slow(slow), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready));
  always #4 pclk = ~pclk;
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one bus transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task drain;
    begin
      for (k = 0; k < 3000 && expq.size() != 0; k++) @(posedge pclk);
      `CHK("queue drained", 0, expq.size())
      repeat (4) @(posedge pclk);
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // compare each byte the host takes with the oldest note
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      `CHK("byte expected", 1'b1, expq.size() != 0)
      if (expq.size() != 0) begin
        b = expq.pop_front();
        `CHK("tx byte", b, tx_byte)
      end
    end
  end
  initial begin
    #(8 * 20000);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, `REG_CTRL, 0, rd, err);
    `CHK("ctrl", 32'h3, rd)
    `CHK("app_run", 1'b1, app_run)
    apb(0, 12'hffc, 0, rd, err);
    `CHK("slverr", 1'b1, err)
    `CHK("slverr data", 32'h0, rd)
    $display("reset test done");
    apb(1, `REG_CTRL, 1, rd, err);
    expq.push_back(8'h09);
    for (i = 0; i < 120; i++) begin
      lfsr = nxt(lfsr);
      apb(1, `REG_TD_BASE + 12'(i * 4), lfsr, rd, err);
      expq.push_back(((i / 30) % 2 == 1 && lfsr[7:0] > 8'h7f) ? 8'h7f : lfsr[7:0]);
    end
    slow <= 1'b1;
    i_host.send(`CMD_TEST_DATA);
    drain;
    apb(0, `REG_IRQ_STAT, 0, rd, err);
    `CHK("td done stat", 32'h1, rd)
    $display("test data done");
    fault_in <= (lfsr[15:0] & 16'h7fff) | 16'h0001;
    repeat (5) @(posedge pclk);
    `CHK("app_run fault", 1'b0, app_run)
    slow <= 1'b0;
    expq.push_back(8'h07);
    expq.push_back(fault_in[15:8]);
    expq.push_back(fault_in[7:0]);
    i_host.send(`CMD_SELF_TEST);
    drain;
    $display("self-test done");
    apb(1, `REG_CTRL, 3, rd, err);
    expq.push_back(8'h07);
    expq.push_back(fault_in[15:8] | 8'h80);
    expq.push_back(fault_in[7:0]);
    fault_in <= fault_in | 16'h8000;
    drain;
    apb(0, `REG_FAULT, 0, rd, err);
    `CHK("fault reg", {fault_in, fault_in}, rd)
    apb(0, `REG_STATUS, 0, rd, err);
    `CHK("status idle", 32'h0, rd)
    $display("unprompted report done");
    apb(1, `REG_IRQ_STAT, 32'hf, rd, err);
    i_host.send(8'h55);
    apb(0, `REG_IRQ_STAT, 0, rd, err);
    `CHK("bad cmd stat", 32'h8, rd)
    `CHK("irq masked", 1'b0, irq)
    apb(1, `REG_IRQ_MASK, 32'h8, rd, err);
    @(posedge pclk);
    `CHK("irq on", 1'b1, irq)
    apb(1, `REG_IRQ_STAT, 32'h8, rd, err);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    $display("interrupt test done");
    apb(1, `REG_CTRL, 0, rd, err);
    i_host.send(`CMD_TEST_DATA);
    repeat (20) @(posedge pclk);
    apb(0, `REG_STATUS, 0, rd, err);
    `CHK("disabled ignores", 32'h0, rd)
    $display("disable test done");
    complete_run;
  end
endmodule
bind selftest_responder selftest_responder_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .fault_in(fault_in),
  .app_run(app_run));
